// file: discharge_protection_config.sv
// discharge protection setup register and fault response logic
`default_nettype none
// Operation
// - setup contents survive sleep; only the power-on reset clears them.
// - disable bit 7 low: discharge overcurrent turns the FETs off.
// - disable bit 7 high: discharge overcurrent leaves the FETs alone.
// - discharge overcurrent always sets its flag and temp sensor supply.
// - disable bit 4 low: short circuit turns the FETs off.
// - disable bit 4 high: short circuit leaves the FETs alone.
// - short circuit always sets its flag and temp sensor supply.
// - bits 6:5 select 0.10, 0.12, 0.14 or 0.16 V overcurrent threshold.
// - bits 3:2 select 0.20, 0.35, 0.65 or 1.20 V short threshold.
// - divider off: time-out codes give 160, 320, 640, 1280 ms.
// - divider on: time-out codes give 2.5, 5, 8, 16 ms.
// - divider bit from another register shortens the time-out.
// - discharge switch bit clears on a fault unless response disabled.
module discharge_protection_config
	import discharge_protection_pkg::*;
#(
	parameter int unsigned TOUT0_CYC = T160MS_US * CLK_MHZ,
	parameter int unsigned TOUT1_CYC = T320MS_US * CLK_MHZ,
	parameter int unsigned TOUT2_CYC = T640MS_US * CLK_MHZ,
	parameter int unsigned TOUT3_CYC = T1280MS_US * CLK_MHZ,
	parameter int unsigned DIV0_CYC  = T2500US_US * CLK_MHZ,
	parameter int unsigned DIV1_CYC  = T5MS_US * CLK_MHZ,
	parameter int unsigned DIV2_CYC  = T8MS_US * CLK_MHZ,
	parameter int unsigned DIV3_CYC  = T16MS_US * CLK_MHZ
) (
	input  wire logic        REF_CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [7:0]  REG_ADDR_I,
	input  wire logic [7:0]  REG_WDATA_I,
	output logic      [7:0]  REG_RDATA_O,
	input  wire logic        DISCHARGE_DELAY_DIVIDER_I,
	input  wire logic        OCD_CMP_I,
	input  wire logic        SCD_CMP_I,
	input  wire logic        OCD_FLAG_CLR_I,
	input  wire logic        SCD_FLAG_CLR_I,
	output logic             DISCHARGE_SWITCH_CTRL_CLR_O,
	output logic             DISCHARGE_OVERCURRENT_FLAG_O,
	output logic             DISCHARGE_SHORT_FLAG_O,
	output logic             TEMP_SENSOR_SUPPLY_OUT_O,
	output logic      [10:0] OCD_THRESH_MV_O,
	output logic      [10:0] SCD_THRESH_MV_O
);
	setup_t           setup;
	setup_t           next_setup;
	logic [7:0]       rdata;
	logic [7:0]       next_rdata;
	thresh_t          thresh;
	thresh_t          next_thresh;
	logic [1:0]       ocd_sync;
	logic [1:0]       scd_sync;
	logic             scd_last;
	logic             ocd_flag;
	logic             scd_flag;
	logic             next_ocd_flag;
	logic             next_scd_flag;
	logic             sw_clr;
	logic             next_sw_clr;
	logic             ocd_evt;
	logic             scd_evt;
	logic [CNT_W-1:0] limit;

	// register access, the bank is kept only by power-on reset
	always_comb begin
		next_setup = setup;
		next_rdata = READ_ZERO;
		if (REG_WR_I && REG_ADDR_I == SETUP_ADDR) begin
			next_setup = setup_t'(REG_WDATA_I);
		end
		if (REG_RD_I && REG_ADDR_I == SETUP_ADDR) begin
			next_rdata = setup;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			setup <= setup_t'(SETUP_RESET);
			rdata <= READ_ZERO;
		end else begin
			setup <= next_setup;
			rdata <= next_rdata;
		end
	end

	assign REG_RDATA_O = rdata;

	// threshold decode
	always_comb begin
		unique case ({setup.discharge_overcurrent_threshold_hi,
			setup.discharge_overcurrent_threshold_lo})
			2'b00: next_thresh.ocd_mv = OCD_MV0;
			2'b01: next_thresh.ocd_mv = OCD_MV1;
			2'b10: next_thresh.ocd_mv = OCD_MV2;
			2'b11: next_thresh.ocd_mv = OCD_MV3;
		endcase
		unique case ({setup.short_circuit_threshold_hi,
			setup.short_circuit_threshold_lo})
			2'b00: next_thresh.scd_mv = SCD_MV0;
			2'b01: next_thresh.scd_mv = SCD_MV1;
			2'b10: next_thresh.scd_mv = SCD_MV2;
			2'b11: next_thresh.scd_mv = SCD_MV3;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			thresh <= '0;
		end else begin
			thresh <= next_thresh;
		end
	end

	assign OCD_THRESH_MV_O = thresh.ocd_mv;
	assign SCD_THRESH_MV_O = thresh.scd_mv;

	// time-out select, divider picks the short set
	always_comb begin
		unique case ({DISCHARGE_DELAY_DIVIDER_I, setup.discharge_timeout_sel_hi,
			setup.discharge_timeout_sel_lo})
			3'b000: limit = CNT_W'(TOUT0_CYC);
			3'b001: limit = CNT_W'(TOUT1_CYC);
			3'b010: limit = CNT_W'(TOUT2_CYC);
			3'b011: limit = CNT_W'(TOUT3_CYC);
			3'b100: limit = CNT_W'(DIV0_CYC);
			3'b101: limit = CNT_W'(DIV1_CYC);
			3'b110: limit = CNT_W'(DIV2_CYC);
			3'b111: limit = CNT_W'(DIV3_CYC);
		endcase
	end

	// comparator pins pass two flops
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ocd_sync <= 2'b00;
			scd_sync <= 2'b00;
			scd_last <= 1'b0;
		end else begin
			ocd_sync <= {ocd_sync[0], OCD_CMP_I};
			scd_sync <= {scd_sync[0], SCD_CMP_I};
			scd_last <= scd_sync[1];
		end
	end

	// overcurrent must persist unbroken for the time-out
	persist_timer ocd_timer (
		.clk_i     (REF_CLK_I),
		.arst_n_i  (ARST_N_I),
		.run_i     (ocd_sync[1]),
		.limit_i   (limit),
		.expired_o (ocd_evt)
	);

	assign scd_evt = scd_sync[1] && !scd_last;

	// sticky flags, set wins over clear; switch clear pulse
	always_comb begin
		next_ocd_flag = ocd_evt || (ocd_flag && !OCD_FLAG_CLR_I);
		next_scd_flag = scd_sync[1] || (scd_flag && !SCD_FLAG_CLR_I);
		next_sw_clr = (ocd_evt && !setup.discharge_overcurrent_auto_off_disable)
			|| (scd_evt && !setup.short_circuit_auto_off_disable);
	end

	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ocd_flag <= 1'b0;
			scd_flag <= 1'b0;
			sw_clr   <= 1'b0;
		end else begin
			ocd_flag <= next_ocd_flag;
			scd_flag <= next_scd_flag;
			sw_clr   <= next_sw_clr;
		end
	end

	assign DISCHARGE_OVERCURRENT_FLAG_O = ocd_flag;
	assign DISCHARGE_SHORT_FLAG_O       = scd_flag;
	assign TEMP_SENSOR_SUPPLY_OUT_O     = ocd_flag || scd_flag;
	assign DISCHARGE_SWITCH_CTRL_CLR_O  = sw_clr;

	// checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	sequence ocd_fault_s;
		ocd_evt && !setup.discharge_overcurrent_auto_off_disable;
	endsequence

	ocd_off_a: assert property (ocd_fault_s |=> sw_clr)
		else $error("overcurrent did not clear switch");
	ocd_keep_a: assert property (
		ocd_evt && setup.discharge_overcurrent_auto_off_disable && !scd_evt
		|=> !sw_clr)
		else $error("disabled overcurrent cleared switch");
	ocd_flag_a: assert property (ocd_evt |=> ocd_flag && TEMP_SENSOR_SUPPLY_OUT_O)
		else $error("overcurrent flag not set");
	scd_off_a: assert property (
		scd_evt && !setup.short_circuit_auto_off_disable |=> sw_clr)
		else $error("short did not clear switch");
	scd_keep_a: assert property (
		scd_evt && setup.short_circuit_auto_off_disable && !ocd_evt
		|=> !sw_clr)
		else $error("disabled short cleared switch");
	scd_flag_a: assert property (scd_sync[1] |=> scd_flag && TEMP_SENSOR_SUPPLY_OUT_O)
		else $error("short flag not set");
	ocd_thr_a: assert property (
		setup.discharge_overcurrent_threshold_hi
		&& setup.discharge_overcurrent_threshold_lo |=> OCD_THRESH_MV_O == OCD_MV3)
		else $error("overcurrent threshold decode wrong");
	scd_thr_a: assert property (
		!setup.short_circuit_threshold_hi && setup.short_circuit_threshold_lo
		|=> SCD_THRESH_MV_O == SCD_MV1)
		else $error("short threshold decode wrong");
	tout_sel_a: assert property (
		DISCHARGE_DELAY_DIVIDER_I && setup.discharge_timeout_sel_hi
		&& setup.discharge_timeout_sel_lo
		|-> limit == CNT_W'(DIV3_CYC) && limit < CNT_W'(TOUT3_CYC))
		else $error("divider did not shorten time-out");
	persist_a: assert property (ocd_evt |-> $past(ocd_sync[1]))
		else $error("overcurrent fault without persistence");
	retain_a: assert property (
		!(REG_WR_I && REG_ADDR_I == SETUP_ADDR) |=> $stable(setup))
		else $error("setup changed without a write");
endmodule : discharge_protection_config
`default_nettype wire

// file: discharge_protection_pkg.sv
// constants and types shared by the discharge protection setup logic
`default_nettype none
package discharge_protection_pkg;
	// register map
	localparam logic [7:0] SETUP_ADDR  = 8'h05;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// clock rate and time-out figures in microseconds
	localparam int unsigned CLK_MHZ     = 50;
	localparam int unsigned T160MS_US   = 160000;
	localparam int unsigned T320MS_US   = 320000;
	localparam int unsigned T640MS_US   = 640000;
	localparam int unsigned T1280MS_US  = 1280000;
	localparam int unsigned T2500US_US  = 2500;
	localparam int unsigned T5MS_US     = 5000;
	localparam int unsigned T8MS_US     = 8000;
	localparam int unsigned T16MS_US    = 16000;
	localparam int unsigned DIV_FACTOR  = 64;
	localparam int unsigned CNT_W       = 27;

	// threshold voltages in millivolts
	localparam logic [10:0] OCD_MV0 = 11'h064;
	localparam logic [10:0] OCD_MV1 = 11'h078;
	localparam logic [10:0] OCD_MV2 = 11'h08C;
	localparam logic [10:0] OCD_MV3 = 11'h0A0;
	localparam logic [10:0] SCD_MV0 = 11'h0C8;
	localparam logic [10:0] SCD_MV1 = 11'h15E;
	localparam logic [10:0] SCD_MV2 = 11'h28A;
	localparam logic [10:0] SCD_MV3 = 11'h4B0;

	// setup register layout, bit 7 first
	typedef struct packed {
		logic discharge_overcurrent_auto_off_disable;
		logic discharge_overcurrent_threshold_hi;
		logic discharge_overcurrent_threshold_lo;
		logic short_circuit_auto_off_disable;
		logic short_circuit_threshold_hi;
		logic short_circuit_threshold_lo;
		logic discharge_timeout_sel_hi;
		logic discharge_timeout_sel_lo;
	} setup_t;

	// decoded thresholds
	typedef struct packed {
		logic [10:0] ocd_mv;
		logic [10:0] scd_mv;
	} thresh_t;
endpackage : discharge_protection_pkg
`default_nettype wire

// file: fet_sense_model.sv
// far side model: current-sense comparators and discharge switch bit
`default_nettype none
module fet_sense_model (
	input  wire logic clk_i,
	input  wire logic ocd_on_i,
	input  wire logic scd_on_i,
	input  wire logic arm_i,
	input  wire logic clr_i,
	output logic      ocd_cmp_o,
	output logic      scd_cmp_o,
	output logic      switch_on_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle: no current, switch off
	initial begin
		ocd_cmp_o = 1'b0;
		scd_cmp_o = 1'b0;
		switch_on_o = 1'b0;
	end
	// comparator levels follow the sensed current
	always @(posedge clk_i) begin
		ocd_cmp_o <= ocd_on_i;
		scd_cmp_o <= scd_on_i;
	end
	// switch cleared by protection pulse, set by software
	always @(posedge clk_i) begin
		if (clr_i) switch_on_o <= 1'b0;
		else if (arm_i) switch_on_o <= 1'b1;
	end
endmodule : fet_sense_model
`default_nettype wire

// file: persist_timer.sv
// persistence timer: pulses once a level has held for limit cycles
`default_nettype none
module persist_timer
	import discharge_protection_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             run_i,
	input  wire logic [CNT_W-1:0] limit_i,
	output logic                  expired_o
);
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// count while the level holds, restart when it drops
	always_comb begin
		next_count = '0;
		if (run_i) begin
			next_count = (count >= limit_i) ? count : count + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// one pulse in the cycle the held time is reached
	assign expired_o = run_i && (count == limit_i - 1'b1);
endmodule : persist_timer
`default_nettype wire

// file: tb_top.sv
// testbench for the discharge protection setup logic
`default_nettype none
module tb_top import discharge_protection_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM [8] = '{10, 20, 30, 40, 3, 5, 8, 16};
	logic clk = 0, arst_n = 0, wr = 0, rd = 0, div = 0, arm = 0;
	logic ocd_on = 0, scd_on = 0, ocd_clr = 0, scd_clr = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic sw_clr, ocd_flag, scd_flag, temp, ocd_cmp, scd_cmp, sw_on;
	logic [10:0] ocd_mv, scd_mv;
	int n_fail = 0, compares = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	// short time-outs keep the run brief; same table the checks expect
	discharge_protection_config #(.TOUT0_CYC(LIM[0]), .TOUT1_CYC(LIM[1]),
		.TOUT2_CYC(LIM[2]), .TOUT3_CYC(LIM[3]), .DIV0_CYC(LIM[4]),
		.DIV1_CYC(LIM[5]), .DIV2_CYC(LIM[6]), .DIV3_CYC(LIM[7]))
		u_discharge_protection_config (
		.REF_CLK_I(clk), .ARST_N_I(arst_n), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_RDATA_O(rdata), .DISCHARGE_DELAY_DIVIDER_I(div),
		.OCD_CMP_I(ocd_cmp), .SCD_CMP_I(scd_cmp),
		.OCD_FLAG_CLR_I(ocd_clr), .SCD_FLAG_CLR_I(scd_clr),
		.DISCHARGE_SWITCH_CTRL_CLR_O(sw_clr),
		.DISCHARGE_OVERCURRENT_FLAG_O(ocd_flag),
		.DISCHARGE_SHORT_FLAG_O(scd_flag),
		.TEMP_SENSOR_SUPPLY_OUT_O(temp),
		.OCD_THRESH_MV_O(ocd_mv), .SCD_THRESH_MV_O(scd_mv));
	fet_sense_model u_fet_sense_model (.clk_i(clk), .ocd_on_i(ocd_on),
		.scd_on_i(scd_on), .arm_i(arm), .clr_i(sw_clr),
		.ocd_cmp_o(ocd_cmp), .scd_cmp_o(scd_cmp), .switch_on_o(sw_on));
	task chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: bit %b not %b", $time, got, exp);
		end
	endtask : chk_bit
	task chk_val(input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: value %h not %h", $time, got, exp);
		end
	endtask : chk_val
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
		tick(2);
	endtask : reg_wr
	task reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 v = rdata;
	endtask : reg_rd
	task t_decode;
		logic [10:0] om [4], sm [4];
		om = '{OCD_MV0, OCD_MV1, OCD_MV2, OCD_MV3};
		sm = '{SCD_MV0, SCD_MV1, SCD_MV2, SCD_MV3};
		for (int i = 0; i < 4; i++) begin
			reg_wr(SETUP_ADDR, {1'b0, 2'(i), 1'b0, 2'(3 - i), 2'(i)});
			chk_val(ocd_mv, om[i]);
			chk_val(scd_mv, sm[3 - i]);
			reg_rd(SETUP_ADDR, d);
			chk_val(11'(d), {3'h0, 1'b0, 2'(i), 1'b0, 2'(3 - i), 2'(i)});
			tick(1);
			chk_val(11'(rdata), 11'h000);
		end
		reg_wr(8'h06, 8'hFF);
		reg_rd(8'h06, d);
		chk_val(11'(d), 11'h000);
		reg_rd(SETUP_ADDR, d);
		chk_val(11'(d), 11'h063);
	endtask : t_decode
	task ocd_fire(input logic [7:0] s, input logic dv, input int lim,
		input bit glitch);
		int n;
		logic seen;
		reg_wr(SETUP_ADDR, s);
		@(posedge clk);
		div <= dv;
		arm <= 1;
		@(posedge clk);
		arm <= 0;
		ocd_on <= 1;
		if (glitch) begin
			repeat (lim - 1) @(posedge clk);
			ocd_on <= 0;
			tick(4);
			chk_bit(ocd_flag, 1'b0);
			@(posedge clk);
			ocd_on <= 1;
		end
		@(posedge clk);
		n = 0;
		seen = 0;
		do begin
			tick(1);
			n++;
			seen |= sw_clr;
		end while (ocd_flag !== 1'b1 && n < lim + 8);
		tick(1);
		seen |= sw_clr;
		chk_bit(n >= lim + 1 && n <= lim + 3, 1'b1);
		chk_bit(temp, 1'b1);
		chk_bit(seen, !s[7]);
		chk_bit(sw_on, s[7]);
		@(posedge clk);
		ocd_on <= 0;
		repeat (4) @(posedge clk);
		ocd_clr <= 1;
		@(posedge clk);
		ocd_clr <= 0;
		tick(2);
		chk_bit(ocd_flag, 1'b0);
		chk_bit(temp, 1'b0);
	endtask : ocd_fire
	task t_short(input logic dis);
		logic seen;
		reg_wr(SETUP_ADDR, {3'b000, dis, 4'h0});
		@(posedge clk);
		arm <= 1;
		@(posedge clk);
		arm <= 0;
		scd_on <= 1;
		seen = 0;
		repeat (6) begin
			tick(1);
			seen |= sw_clr;
		end
		chk_bit(scd_flag, 1'b1);
		chk_bit(temp, 1'b1);
		chk_bit(seen, !dis);
		chk_bit(sw_on, dis);
		@(posedge clk);
		scd_clr <= 1;
		@(posedge clk);
		scd_clr <= 0;
		scd_on <= 0;
		tick(2);
		chk_bit(scd_flag, 1'b1);
		@(posedge clk);
		scd_clr <= 1;
		@(posedge clk);
		scd_clr <= 0;
		tick(2);
		chk_bit(scd_flag, 1'b0);
	endtask : t_short
	task end_of_test;
		$display("n_fail %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1;
		tick(1);
		chk_val(ocd_mv, OCD_MV0);
		reg_rd(SETUP_ADDR, d);
		chk_val(11'(d), 11'(SETUP_RESET));
		t_decode();
		for (int k = 0; k < 8; k++)
			ocd_fire(8'(k % 4), 1'(k / 4), LIM[k], 1'b0);
		ocd_fire(8'h81, 1'b0, LIM[1], 1'b0);
		ocd_fire(8'h02, 1'b1, LIM[6], 1'b1);
		t_short(1'b0);
		t_short(1'b1);
		end_of_test();
	end
	// watchdog
	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
